/* hw/fep_pkg.sv */
// Constants, carriers and code-group helpers for the 100 Mb/s coding path
package fep_pkg;
    localparam int CLK_NS = 25;
    localparam int TX_BIT_NS = 200;
    localparam int TX_DIV = (TX_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOSS_NS = 1600;
    localparam int LOSS_CYC = (LOSS_NS / CLK_NS < 1) ? 1 : LOSS_NS / CLK_NS;
    localparam int LOCK_EDGES = 16;
    localparam int DSCR_LOCK_BITS = 30;
    localparam int SAMPLE_W = 6;
    localparam int PEAK_INIT = 16;
    localparam int FIFO_DEPTH = 8;
    localparam logic [10:0] LFSR_SEED = 11'h7ff;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0d;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_I = 5'h1f;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_POS = 2'h1;
    localparam logic [1:0] LVL_NEG = 2'h2;

    typedef struct packed {
        logic last;        // Transmit enable drops after this word
        logic [4:0] data;  // Nibble in [3:0], whole group in bypass
    } fep_tx_word_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] data;
    } fep_rx_nib_t;

    typedef struct packed {
        logic [10:0] state;
        logic [4:0] key;
    } fep_scr_t;

    function automatic logic [4:0] fep_enc(input logic [3:0] n);
        case (n)
            4'h0: return 5'h1e;
            4'h1: return 5'h09;
            4'h2: return 5'h14;
            4'h3: return 5'h15;
            4'h4: return 5'h0a;
            4'h5: return 5'h0b;
            4'h6: return 5'h0e;
            4'h7: return 5'h0f;
            4'h8: return 5'h12;
            4'h9: return 5'h13;
            4'ha: return 5'h16;
            4'hb: return 5'h17;
            4'hc: return 5'h1a;
            4'hd: return 5'h1b;
            4'he: return 5'h1c;
            default: return 5'h1d;
        endcase
    endfunction

    // Returns {valid, nibble}; valid is low for every non-data group
    function automatic logic [4:0] fep_dec(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (fep_enc(4'(i)) == c) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Key bit of the eleven-stage generator, x^11 + x^9 + 1
    function automatic logic fep_key(input logic [10:0] s);
        return s[10] ^ s[8];
    endfunction

    function automatic fep_scr_t fep_scr5(input logic [10:0] s);
        fep_scr_t r;
        r.state = s;
        r.key = 5'h00;
        for (int i = 4; i >= 0; i--) begin
            r.key[i] = fep_key(r.state);
            r.state = {r.state[9:0], r.key[i]};
        end
        return r;
    endfunction
endpackage

/* hw/fep_pcs.sv */
// Nibble FIFO and the 100 Mb/s transmit and receive coding path
`timescale 1ns/10ps

module fep_fifo #(
    parameter int W = 6,
    parameter int DEPTH = 8
) (
    input wire logic clock,           // System clock
    input wire logic sys_rst,         // Synchronous reset
    input wire logic in_valid,        // Write request
    output logic in_ready,            // Room for a word
    input wire logic [W-1:0] in_data, // Write data
    output logic out_valid,           // Word available
    input wire logic out_ready,       // Read accept
    output logic [W-1:0] out_data     // Head word
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } fep_fifo_st_t;
    fep_fifo_st_t st_r;
    fep_fifo_st_t st_nxt;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid && st_r.rdy;
        pop = out_ready && (st_r.cnt != '0);
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Ready follows the next count, so the source sees a flop and no word is lost
        st_nxt.rdy = (st_nxt.cnt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready = st_r.rdy;
    assign out_valid = (st_r.cnt != '0);
    assign out_data = st_r.mem[st_r.rp];
endmodule // fep_fifo

module fep_pcs #(
    parameter int SW = fep_pkg::SAMPLE_W,
    parameter int DEPTH = fep_pkg::FIFO_DEPTH
) (
    input wire logic clock,                        // 40 MHz system clock
    input wire logic sys_rst,                      // Synchronous reset
    input wire logic tx_valid,                     // Transmit word offered
    output logic tx_ready,                         // Transmit FIFO has room
    input wire fep_pkg::fep_tx_word_t tx_word,     // Nibble and end flag
    input wire logic bypass_4b5b,                  // Send raw 5-bit groups
    output logic tx_pos,                           // Driver side A
    output logic tx_neg,                           // Driver side B
    input wire logic rx_link_clk,                  // Recovered line clock
    input wire logic signed [SW-1:0] rx_sample,    // Equalizer input sample
    output logic rx_locked,                        // Line clock present
    output logic rx_strobe,                        // New nibble, one cycle
    output fep_pkg::fep_rx_nib_t rx_nib            // Received nibble
);
    import fep_pkg::*;

    typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_T, TX_R} fep_tx_st_t;

    typedef struct packed {
        fep_tx_st_t txs;
        logic [3:0] div;
        logic [2:0] bcnt;
        logic [4:0] sh;
        logic [10:0] tx_lfsr;
        logic nrzi;
        logic [1:0] mlt;
        logic pos;
        logic neg;
        logic pop;
        logic [2:0] clk_s;
        logic [1:0][SW-1:0] smp_s;
        logic [SW-1:0] peak;
        logic [1:0] lvl;
        logic rx_nrzi;
        logic [4:0] edges;
        logic [7:0] quiet;
        logic lock;
        logic [10:0] rx_lfsr;
        logic [5:0] dcnt;
        logic dlock;
        logic [9:0] win;
        logic in_frame;
        logic [2:0] gcnt;
        logic pend_t;
        logic pre2;
        logic strobe;
        fep_rx_nib_t nib;
    } fep_st_t;

    fep_st_t st_r;
    fep_st_t st_nxt;
    logic f_valid;
    fep_tx_word_t f_word;
    fep_scr_t scr;
    logic [4:0] grp;
    logic [4:0] cur;
    logic bit_en;
    logic tx_bit;
    logic edge_seen;
    logic signed [SW-1:0] smp;
    logic [SW-1:0] mag;
    logic [SW-1:0] thr;
    logic [1:0] lvl;
    logic nrzi_new;
    logic nrz;
    logic key;
    logic plain;
    logic [4:0] dec;

    fep_fifo #(.W($bits(fep_tx_word_t)), .DEPTH(DEPTH)) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_word),
        .out_valid(f_valid),
        .out_ready(st_r.pop),
        .out_data(f_word)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.pop = 1'b0;
        st_nxt.strobe = 1'b0;
        grp = CG_I;
        cur = st_r.sh;
        tx_bit = 1'b0;
        scr = fep_scr5(st_r.tx_lfsr);
        // Line bit rate is a divider enable, not a second clock
        bit_en = (st_r.div == 4'(TX_DIV - 1));
        st_nxt.div = bit_en ? 4'h0 : st_r.div + 4'h1;

        // Pop is registered, so the head word is only sampled on a group start
        if (bit_en && st_r.bcnt == 3'h0) begin
            unique case (st_r.txs)
                TX_IDLE: begin
                    if (f_valid && bypass_4b5b) begin
                        grp = f_word.data;
                        st_nxt.pop = 1'b1;
                    end else if (f_valid) begin
                        grp = CG_J;
                        st_nxt.pop = 1'b1;
                        st_nxt.txs = TX_K;
                    end else begin
                        grp = CG_I;
                    end
                end
                TX_K: begin
                    grp = CG_K;
                    st_nxt.pop = f_valid;
                    st_nxt.txs = TX_DATA;
                end
                TX_DATA: begin
                    if (f_valid) begin
                        grp = fep_enc(f_word.data[3:0]);
                        st_nxt.pop = 1'b1;
                        if (f_word.last) begin
                            st_nxt.txs = TX_T;
                        end
                    end else begin
                        // Underrun mid-frame: mark it on the line, then close
                        grp = CG_H;
                        st_nxt.txs = TX_T;
                    end
                end
                TX_T: begin
                    grp = CG_T;
                    st_nxt.txs = TX_R;
                end
                TX_R: begin
                    grp = CG_R;
                    st_nxt.txs = TX_IDLE;
                end
            endcase
            cur = grp ^ scr.key;
            st_nxt.tx_lfsr = scr.state;
        end

        if (bit_en) begin
            tx_bit = cur[4];
            st_nxt.sh = {cur[3:0], 1'b0};
            st_nxt.bcnt = (st_r.bcnt == 3'h4) ? 3'h0 : st_r.bcnt + 3'h1;
            st_nxt.nrzi = st_r.nrzi ^ tx_bit;
            // Each NRZI transition steps 0,+,0,- so ones alternate sides
            st_nxt.mlt = st_r.mlt + 2'(tx_bit);
            st_nxt.pos = (st_nxt.mlt == 2'h1);
            st_nxt.neg = (st_nxt.mlt == 2'h3);
        end

        // Receive side: clock and samples pass two flops before use
        // Third clock flop only keeps the last level for edge finding
        st_nxt.clk_s = {st_r.clk_s[1:0], rx_link_clk};
        st_nxt.smp_s = {st_r.smp_s[0], rx_sample};
        edge_seen = st_r.clk_s[1] && !st_r.clk_s[2];
        smp = $signed(st_r.smp_s[1]);
        mag = smp[SW-1] ? SW'(-smp) : SW'(smp);
        thr = st_r.peak >> 1;
        lvl = LVL_ZERO;
        if (smp > $signed({1'b0, thr[SW-2:0]})) begin
            lvl = LVL_POS;
        end else if (-smp > $signed({1'b0, thr[SW-2:0]})) begin
            lvl = LVL_NEG;
        end
        nrzi_new = st_r.rx_nrzi ^ (lvl != st_r.lvl);
        nrz = nrzi_new ^ st_r.rx_nrzi;
        key = fep_key(st_r.rx_lfsr);
        plain = nrz ^ key;
        // Decode the window as it stands once this bit is shifted in;
        // the window field itself is only updated further down
        dec = fep_dec({st_r.win[3:0], plain});

        if (edge_seen) begin
            st_nxt.quiet = 8'h00;
            if (st_r.edges != 5'(LOCK_EDGES)) begin
                st_nxt.edges = st_r.edges + 5'h1;
            end else begin
                st_nxt.lock = 1'b1;
            end
        end else if (st_r.quiet == 8'(LOSS_CYC - 1)) begin
            // Line gone: a frame in progress is dropped, not closed
            st_nxt.lock = 1'b0;
            st_nxt.edges = 5'h0;
            st_nxt.dlock = 1'b0;
            st_nxt.dcnt = 6'h0;
            st_nxt.in_frame = 1'b0;
            st_nxt.nib.dv = 1'b0;
        end else begin
            st_nxt.quiet = st_r.quiet + 8'h1;
        end

        if (edge_seen && st_r.lock) begin
            // Slicer follows the peak, so cable loss scales the threshold
            if (mag > thr) begin
                st_nxt.peak = SW'($signed({1'b0, st_r.peak}) +
                    ($signed({1'b0, mag}) - $signed({1'b0, st_r.peak})) / 8);
            end
            st_nxt.lvl = lvl;
            st_nxt.rx_nrzi = nrzi_new;
            st_nxt.win = {st_r.win[8:0], plain};
            if (!st_r.dlock) begin
                // Idle is all ones, so an inverted bit reveals the key
                st_nxt.rx_lfsr = {st_r.rx_lfsr[9:0], ~nrz};
                st_nxt.dcnt = plain ? st_r.dcnt + 6'h1 : 6'h0;
                st_nxt.dlock = (st_nxt.dcnt == 6'(DSCR_LOCK_BITS));
            end else begin
                st_nxt.rx_lfsr = {st_r.rx_lfsr[9:0], key};
            end

            if (!st_r.in_frame) begin
                if (st_r.dlock && st_nxt.win == {CG_J, CG_K}) begin
                    st_nxt.in_frame = 1'b1;
                    st_nxt.gcnt = 3'h0;
                    st_nxt.pend_t = 1'b0;
                    st_nxt.pre2 = 1'b1;
                    st_nxt.strobe = 1'b1;
                    st_nxt.nib = '{dv: 1'b1, er: 1'b0, data: NIB_PREAMBLE};
                end
            end else if (st_r.gcnt == 3'h4) begin
                st_nxt.gcnt = 3'h0;
                if (st_r.pend_t || st_nxt.win[4:0] == CG_I) begin
                    st_nxt.in_frame = 1'b0;
                    st_nxt.nib.dv = 1'b0;
                end else if (st_nxt.win[4:0] == CG_T) begin
                    st_nxt.pend_t = 1'b1;
                end else begin
                    st_nxt.strobe = 1'b1;
                    st_nxt.nib = '{dv: 1'b1, er: !dec[4], data: dec[3:0]};
                end
            end else begin
                st_nxt.gcnt = st_r.gcnt + 3'h1;
            end
        end else if (st_r.pre2) begin
            // Second preamble nibble goes out one cycle after the first
            st_nxt.pre2 = 1'b0;
            st_nxt.strobe = 1'b1;
            st_nxt.nib = '{dv: 1'b1, er: 1'b0, data: NIB_PREAMBLE};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.txs <= TX_IDLE;
            st_r.tx_lfsr <= LFSR_SEED;
            st_r.peak <= SW'(PEAK_INIT);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_pos = st_r.pos;
    assign tx_neg = st_r.neg;
    assign rx_locked = st_r.lock;
    assign rx_strobe = st_r.strobe;
    assign rx_nib = st_r.nib;
endmodule // fep_pcs

/* bench/fep_line_model.sv */
// Line model: loops the MLT-3 driver pair back as receive samples
`timescale 1ns/10ps
module fep_line_model #(
    parameter int SW = 6,
    parameter int AMP = 24
) (
    input wire logic tx_pos,               // Driver side A
    input wire logic tx_neg,               // Driver side B
    output logic rx_link_clk,              // Line clock
    output logic signed [SW-1:0] rx_sample // Three-level sample
);
    // Idle groups fill the line, so the clock runs free
    initial begin
        rx_link_clk = 1'b0;
        rx_sample = '0;
        #3;
        forever begin
            #100 rx_link_clk = ~rx_link_clk;
            // Changed on the fall so it is stable around the rise
            if (!rx_link_clk) begin
                rx_sample = tx_pos ? SW'(AMP) : (tx_neg ? -SW'(AMP) : '0);
            end
        end
    end
endmodule // fep_line_model

/* bench/fep_pcs_asserts.sv */
// Port checker for the coding path
`timescale 1ns/10ps
module fep_pcs_asserts
    import fep_pkg::*;
#(
    parameter int SW = 6,
    parameter int DEPTH = 8
) (
    input wire logic clock,                     // Clock
    input wire logic sys_rst,                   // Reset
    input wire logic tx_valid,                  // Word offered
    input wire logic tx_ready,                  // Room
    input wire fep_pkg::fep_tx_word_t tx_word,  // Word
    input wire logic bypass_4b5b,               // Bypass
    input wire logic tx_pos,                    // Side A
    input wire logic tx_neg,                    // Side B
    input wire logic rx_link_clk,               // Line clock
    input wire logic signed [SW-1:0] rx_sample, // Sample
    input wire logic rx_locked,                 // Locked
    input wire logic rx_strobe,                 // Strobe
    input wire fep_pkg::fep_rx_nib_t rx_nib     // Nibble
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_pre;
        rx_strobe && rx_nib.data == NIB_PREAMBLE;
    endsequence
    AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=> tx_ready && !tx_pos && !tx_neg
        && !rx_locked && !rx_strobe && rx_nib == 6'h00) else $error("outputs not at reset values");
    AST_MLT_EXCL: assert property (!(tx_pos && tx_neg)) else $error("both driver sides high");
    AST_MLT_STEP: assert property ($rose(tx_pos) |-> !$past(tx_neg)) else $error("line skipped zero");
    AST_BIT_HOLD: assert property ($changed({tx_pos, tx_neg}) |=> $stable({tx_pos, tx_neg})[*7])
        else $error("line bit shorter than eight cycles");
    AST_STROBE_PAIR: assert property (rx_strobe[*2] |=> !rx_strobe) else $error("strobe run too long");
    AST_PREAMBLE: assert property ($rose(rx_nib.dv) |-> s_pre ##1 s_pre) else $error("frame not opened by two preambles");
    AST_ER_DATA: assert property (rx_strobe && rx_nib.er |-> rx_nib.data == 4'h0) else $error("error nibble not zero");
    AST_UNLOCKED: assert property (!rx_locked && !$past(rx_locked) |-> !rx_strobe && !rx_nib.dv)
        else $error("nibble while unlocked");
    AST_STROBE_GAP: assert property (rx_strobe ##1 !rx_strobe |-> !rx_strobe[*8]) else $error("groups too close");
    AST_READY_FELL: assert property ($fell(tx_ready) |-> $past(tx_valid)) else $error("ready fell without a write");
endmodule // fep_pcs_asserts

bind fep_pcs fep_pcs_asserts #(.SW(SW), .DEPTH(DEPTH)) u_chk (.clock(clock), .sys_rst(sys_rst),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word), .bypass_4b5b(bypass_4b5b), .tx_pos(tx_pos),
    .tx_neg(tx_neg), .rx_link_clk(rx_link_clk), .rx_sample(rx_sample), .rx_locked(rx_locked),
    .rx_strobe(rx_strobe), .rx_nib(rx_nib));

/* bench/fep_pcs_test.sv */
// Loopback testbench for the coding path
`timescale 1ns/10ps
module fep_pcs_test;
    import fep_pkg::*;
    logic clock, sys_rst, tx_valid, tx_ready, bypass_4b5b, tx_pos, tx_neg, rx_link_clk, rx_locked, rx_strobe;
    logic signed [5:0] rx_sample;
    fep_tx_word_t tx_word;
    fep_rx_nib_t rx_nib;
    logic [4:0] rxq[$];
    logic [4:0] q[$];
    logic [4:0] p[$];
    int mismatches = 0;
    int n_tests = 0;
    int stall;

    fep_pcs u_dut (.clock(clock), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_word(tx_word), .bypass_4b5b(bypass_4b5b), .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_link_clk(rx_link_clk),
        .rx_sample(rx_sample), .rx_locked(rx_locked), .rx_strobe(rx_strobe), .rx_nib(rx_nib));
    fep_line_model u_line (.tx_pos(tx_pos), .tx_neg(tx_neg), .rx_link_clk(rx_link_clk), .rx_sample(rx_sample));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(negedge clock) begin
        if (rx_strobe === 1'b1) begin
            rxq.push_back({rx_nib.er, rx_nib.data});
        end
    end

    task automatic cmp(input string what, input logic [5:0] exp, input logic [5:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmpn(input string what, input int exp, input int got);
        n_tests++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Word held until taken; ready is registered, so the fall edge shows the next take
    task automatic frame(input logic [4:0] ws[$], input logic close, output int stall_at);
        int n;
        stall_at = -1;
        @(negedge clock);
        foreach (ws[i]) begin
            tx_word = '{last: close && (i == ws.size() - 1), data: ws[i]};
            tx_valid = 1'b1;
            n = 0;
            while (tx_ready !== 1'b1 && n < 400) begin
                if (stall_at < 0) stall_at = i;
                @(negedge clock);
                n++;
            end
            cmpn("accept wait", 1, int'(n < 400));
            @(negedge clock);
        end
        tx_valid = 1'b0;
    endtask

    task automatic check_rx(input string what, input logic [4:0] exp[$]);
        int n;
        n = 0;
        while (rxq.size() < exp.size() && n < 3000) begin
            @(negedge clock);
            n++;
        end
        // Extra wait lets a stray delimiter nibble show up
        repeat (200) @(negedge clock);
        cmpn({what, " count"}, exp.size(), rxq.size());
        foreach (exp[i]) begin
            if (i < rxq.size()) cmp(what, {1'b0, exp[i]}, {1'b0, rxq[i]});
        end
        rxq.delete();
        $display("test %s done", what);
    endtask

    task automatic t_reset();
        cmp("reset outputs", 6'h20, {tx_ready, tx_pos, tx_neg, rx_locked, rx_strobe, 1'b0});
        cmp("reset nibble", 6'h00, rx_nib);
        sys_rst = 1'b0;
        repeat (800) @(negedge clock);
        cmp("locked", 6'h01, {5'h00, rx_locked});
        cmpn("idle nibbles", 0, rxq.size());
        $display("test reset done");
    endtask

    task automatic t_table();
        q = {5'h05, 5'h05};
        for (int i = 0; i < 16; i++) q.push_back(5'(i));
        p = {5'h05, 5'h05, 5'h0a};
        frame(q, 1'b1, stall);
        cmp("fifo fill", 6'h01, {5'h00, stall >= FIFO_DEPTH && stall <= FIFO_DEPTH + 2});
        frame(p, 1'b1, stall);
        q = {q, p};
        check_rx("table", q);
    endtask

    task automatic t_underrun();
        q = {5'h05, 5'h05, 5'h06, 5'h07};
        frame(q, 1'b0, stall);
        q.push_back(5'h10);
        check_rx("underrun", q);
        cmp("frame closed", 6'h00, {5'h00, rx_nib.dv});
    endtask

    task automatic t_bypass();
        bypass_4b5b = 1'b1;
        q = {CG_J, CG_K, 5'h15, 5'h1e, CG_T, CG_R};
        frame(q, 1'b1, stall);
        p = {5'h05, 5'h05, 5'h03, 5'h00};
        check_rx("bypass", p);
        bypass_4b5b = 1'b0;
    endtask

    initial begin
        #500000;
        mismatches++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        sys_rst = 1'b1;
        tx_valid = 1'b0;
        tx_word = '0;
        bypass_4b5b = 1'b0;
        repeat (2) @(negedge clock);
        t_reset();
        t_table();
        t_underrun();
        t_bypass();
        conclude();
    end
endmodule // fep_pcs_test
